// ===== bxcvr_pkg.sv
// Purpose: Shared constants for the bidirectional latch and flop bus transceiver.
// Assumes: One 200 MHz clock; all pins sampled synchronously.
// Notes: Index 0 is the A-to-B path, index 1 the B-to-A path.
package bxcvr_pkg;
  localparam int DATA_W = 18;
  localparam int FIFO_DEPTH = 16;
  localparam int PATH_AB = 0;
  localparam int PATH_BA = 1;
  localparam logic [DATA_W-1:0] STORE_RST = 18'h00000;
  localparam logic [DATA_W-1:0] KEEP_RST = 18'h00000;
  localparam logic DRIVE_RST = 1'b0;
  localparam logic CLOCK_N_RST = 1'b0;
endpackage

// ===== bxcvr_fifo.sv
// Purpose: Small FIFO with valid and ready on both sides and a registered read port.
// Assumes: Flush and push never matter in the same cycle to the caller.
// Notes: The output register adds one word of capacity beyond the memory depth.
`timescale 1ns/1ps
module bxcvr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop_mem;

  //////////////////////////////////////////////////////////////////////////////
  assign in_ready_out = (count_reg < CW'(DEPTH));
  assign push = in_valid_in && in_ready_out && !flush_in;
  assign pop_mem = (count_reg != '0) && (!out_valid_out || out_ready_in) && !flush_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
      end
      if (pop_mem) begin
        rd_ptr_reg <= PW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= CW'(count_reg + CW'(push) - CW'(pop_mem));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (flush_in) begin
      out_valid_out <= 1'b0;
    end else if (pop_mem) begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rd_ptr_reg];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule // bxcvr_fifo

// ===== bxcvr_top.sv
// Purpose: Eighteen-bit two-way bus transceiver with latch or flop storage per direction.
// Assumes: All inputs synchronous to clk_in; the clock inputs are sampled, not used as clocks.
// Notes: Captures queue in a FIFO and drain while the path is enabled and latched.
//
// What this block does
// RULE1: Carry 18 bits between A and B, one storage element per bit each way.
// RULE2: A-to-B latch enable high makes the path transparent, A flows to B.
// RULE3: Latch enable low with a steady clock holds the stored value on B; here a capture queued while output enable was low lands on B once it rises.
// RULE4: Latch enable low, each falling A-to-B clock edge captures the A bus; here a fall is dropped while the capture queue is full.
// RULE5: A-to-B output enable high drives the B port from the stored path.
// RULE6: A-to-B output enable low releases every B pin, whatever else happens.
// RULE7: B-to-A path works the same way under its own three controls.
// RULE8: B-to-A output enable is active low: low drives A, high releases it.
// RULE9: Undriven data inputs keep their last valid level.
// RULE10: Clock held low after latch enable falls keeps the previous output.
// RULE11: Latch enable falling with steady clock keeps the value passing through.
`timescale 1ns/1ps
module bxcvr_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // A-to-B controls
  input wire logic a_to_b_output_enable_in,
  input wire logic a_to_b_latch_enable_in,
  input wire logic a_to_b_clock_n_in,
  // B-to-A controls
  input wire logic b_to_a_output_enable_n_in,
  input wire logic b_to_a_latch_enable_in,
  input wire logic b_to_a_clock_n_in,
  // A port pins
  input wire logic [bxcvr_pkg::DATA_W-1:0] a_pin_in,
  output logic [bxcvr_pkg::DATA_W-1:0] a_pin_out,
  output logic a_pin_oe_out,
  // B port pins
  input wire logic [bxcvr_pkg::DATA_W-1:0] b_pin_in,
  output logic [bxcvr_pkg::DATA_W-1:0] b_pin_out,
  output logic b_pin_oe_out,
  // Capture queue status
  output logic a_to_b_capture_ready_out,
  output logic b_to_a_capture_ready_out
);
  localparam int W = bxcvr_pkg::DATA_W;

  logic [W-1:0] keep_reg [2];
  logic [W-1:0] store_reg [2];
  logic drive_reg [2];
  logic clock_n_prev_reg [2];
  logic ready_reg [2];
  logic latch_en [2];
  logic clock_n [2];
  logic out_en [2];
  logic fall [2];
  logic push_req [2];
  logic fifo_in_ready [2];
  logic fifo_out_valid [2];
  logic fifo_out_ready [2];
  logic [W-1:0] fifo_out_data [2];

  // A falling edge is a high sample followed by a low one; a pin idling low never fires.
  function automatic logic is_fall(input logic prev, input logic now);
    is_fall = prev && !now;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Control gathering; the B-to-A enable is inverted here so both paths share logic.
  assign latch_en[bxcvr_pkg::PATH_AB] = a_to_b_latch_enable_in;
  assign latch_en[bxcvr_pkg::PATH_BA] = b_to_a_latch_enable_in; // [RULE7]
  assign clock_n[bxcvr_pkg::PATH_AB] = a_to_b_clock_n_in;
  assign clock_n[bxcvr_pkg::PATH_BA] = b_to_a_clock_n_in; // [RULE7]
  assign out_en[bxcvr_pkg::PATH_AB] = a_to_b_output_enable_in; // [RULE5]
  assign out_en[bxcvr_pkg::PATH_BA] = !b_to_a_output_enable_n_in; // [RULE8]

  //////////////////////////////////////////////////////////////////////////////
  // Bus keepers: a pin we drive ourselves reads back our own data, so hold instead.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      keep_reg[bxcvr_pkg::PATH_AB] <= bxcvr_pkg::KEEP_RST;
      keep_reg[bxcvr_pkg::PATH_BA] <= bxcvr_pkg::KEEP_RST;
    end else begin
      if (!a_pin_oe_out) begin
        keep_reg[bxcvr_pkg::PATH_AB] <= a_pin_in; // [RULE9]
      end
      if (!b_pin_oe_out) begin
        keep_reg[bxcvr_pkg::PATH_BA] <= b_pin_in; // [RULE9]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock edge detection, both directions.
  assign fall[bxcvr_pkg::PATH_AB] = is_fall(clock_n_prev_reg[bxcvr_pkg::PATH_AB],
    clock_n[bxcvr_pkg::PATH_AB]);
  assign fall[bxcvr_pkg::PATH_BA] = is_fall(clock_n_prev_reg[bxcvr_pkg::PATH_BA],
    clock_n[bxcvr_pkg::PATH_BA]); // [RULE7]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_n_prev_reg[bxcvr_pkg::PATH_AB] <= bxcvr_pkg::CLOCK_N_RST;
      clock_n_prev_reg[bxcvr_pkg::PATH_BA] <= bxcvr_pkg::CLOCK_N_RST;
    end else begin
      clock_n_prev_reg[bxcvr_pkg::PATH_AB] <= clock_n[bxcvr_pkg::PATH_AB];
      clock_n_prev_reg[bxcvr_pkg::PATH_BA] <= clock_n[bxcvr_pkg::PATH_BA];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture requests; transparent mode ignores the clock entirely.
  assign push_req[bxcvr_pkg::PATH_AB] = fall[bxcvr_pkg::PATH_AB] &&
    !latch_en[bxcvr_pkg::PATH_AB]; // [RULE4]
  assign push_req[bxcvr_pkg::PATH_BA] = fall[bxcvr_pkg::PATH_BA] &&
    !latch_en[bxcvr_pkg::PATH_BA]; // [RULE7]

  // Queued captures drain only while the port is enabled, so a disabled port backs up.
  assign fifo_out_ready[bxcvr_pkg::PATH_AB] = out_en[bxcvr_pkg::PATH_AB] &&
    !latch_en[bxcvr_pkg::PATH_AB];
  assign fifo_out_ready[bxcvr_pkg::PATH_BA] = out_en[bxcvr_pkg::PATH_BA] &&
    !latch_en[bxcvr_pkg::PATH_BA];

  //////////////////////////////////////////////////////////////////////////////
  // A-to-B capture queue; flushed while transparent so stale captures never surface.
  bxcvr_fifo #(
    .WIDTH(bxcvr_pkg::DATA_W),
    .DEPTH(bxcvr_pkg::FIFO_DEPTH)
  ) u_bxcvr_fifo_ab (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(latch_en[bxcvr_pkg::PATH_AB]),
    .in_valid_in(push_req[bxcvr_pkg::PATH_AB]),
    .in_ready_out(fifo_in_ready[bxcvr_pkg::PATH_AB]),
    .in_data_in(keep_reg[bxcvr_pkg::PATH_AB]),
    .out_valid_out(fifo_out_valid[bxcvr_pkg::PATH_AB]),
    .out_ready_in(fifo_out_ready[bxcvr_pkg::PATH_AB]),
    .out_data_out(fifo_out_data[bxcvr_pkg::PATH_AB])
  );

  //////////////////////////////////////////////////////////////////////////////
  // B-to-A capture queue, the mirror of the one above.
  bxcvr_fifo #(
    .WIDTH(bxcvr_pkg::DATA_W),
    .DEPTH(bxcvr_pkg::FIFO_DEPTH)
  ) u_bxcvr_fifo_ba (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(latch_en[bxcvr_pkg::PATH_BA]),
    .in_valid_in(push_req[bxcvr_pkg::PATH_BA]),
    .in_ready_out(fifo_in_ready[bxcvr_pkg::PATH_BA]),
    .in_data_in(keep_reg[bxcvr_pkg::PATH_BA]),
    .out_valid_out(fifo_out_valid[bxcvr_pkg::PATH_BA]),
    .out_ready_in(fifo_out_ready[bxcvr_pkg::PATH_BA]),
    .out_data_out(fifo_out_data[bxcvr_pkg::PATH_BA])
  );

  //////////////////////////////////////////////////////////////////////////////
  // Storage elements; transparent data wins over a queued capture.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      store_reg[bxcvr_pkg::PATH_AB] <= bxcvr_pkg::STORE_RST; // [RULE1]
      store_reg[bxcvr_pkg::PATH_BA] <= bxcvr_pkg::STORE_RST; // [RULE1]
    end else begin
      if (latch_en[bxcvr_pkg::PATH_AB]) begin
        store_reg[bxcvr_pkg::PATH_AB] <= keep_reg[bxcvr_pkg::PATH_AB]; // [RULE2] [RULE11]
      end else if (fifo_out_valid[bxcvr_pkg::PATH_AB] &&
          fifo_out_ready[bxcvr_pkg::PATH_AB]) begin
        store_reg[bxcvr_pkg::PATH_AB] <= fifo_out_data[bxcvr_pkg::PATH_AB]; // [RULE4]
      end
      if (latch_en[bxcvr_pkg::PATH_BA]) begin
        store_reg[bxcvr_pkg::PATH_BA] <= keep_reg[bxcvr_pkg::PATH_BA]; // [RULE7] [RULE11]
      end else if (fifo_out_valid[bxcvr_pkg::PATH_BA] &&
          fifo_out_ready[bxcvr_pkg::PATH_BA]) begin
        store_reg[bxcvr_pkg::PATH_BA] <= fifo_out_data[bxcvr_pkg::PATH_BA]; // [RULE7]
      end
      // Otherwise the value is held, clock high or low alike. [RULE3] [RULE10]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output drive; the enable costs one cycle so the pin enable comes from a flop.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_reg[bxcvr_pkg::PATH_AB] <= bxcvr_pkg::DRIVE_RST;
      drive_reg[bxcvr_pkg::PATH_BA] <= bxcvr_pkg::DRIVE_RST;
    end else begin
      drive_reg[bxcvr_pkg::PATH_AB] <= out_en[bxcvr_pkg::PATH_AB]; // [RULE5] [RULE6]
      drive_reg[bxcvr_pkg::PATH_BA] <= out_en[bxcvr_pkg::PATH_BA]; // [RULE8]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Queue status; one cycle late, so a writer must allow one extra dropped capture.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_reg[bxcvr_pkg::PATH_AB] <= 1'b0;
      ready_reg[bxcvr_pkg::PATH_BA] <= 1'b0;
    end else begin
      ready_reg[bxcvr_pkg::PATH_AB] <= fifo_in_ready[bxcvr_pkg::PATH_AB];
      ready_reg[bxcvr_pkg::PATH_BA] <= fifo_in_ready[bxcvr_pkg::PATH_BA];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin outputs, straight from flops.
  assign b_pin_out = store_reg[bxcvr_pkg::PATH_AB];
  assign b_pin_oe_out = drive_reg[bxcvr_pkg::PATH_AB]; // [RULE6]
  assign a_pin_out = store_reg[bxcvr_pkg::PATH_BA];
  assign a_pin_oe_out = drive_reg[bxcvr_pkg::PATH_BA]; // [RULE8]
  assign a_to_b_capture_ready_out = ready_reg[bxcvr_pkg::PATH_AB];
  assign b_to_a_capture_ready_out = ready_reg[bxcvr_pkg::PATH_BA];
endmodule // bxcvr_top

// ===== bxcvr_props.sv
// Purpose: Port checker for the transceiver.
// Assumes: Every port is sampled on the rising edge of clk_in.
// Notes: Off during reset, since the pipeline then holds reset values.
`timescale 1ns/1ps
module bxcvr_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Controls
  input wire logic a_to_b_output_enable_in,
  input wire logic a_to_b_latch_enable_in,
  input wire logic b_to_a_output_enable_n_in,
  input wire logic b_to_a_latch_enable_in,
  // Pins
  input wire logic [17:0] a_pin_in,
  input wire logic [17:0] a_pin_out,
  input wire logic a_pin_oe_out,
  input wire logic [17:0] b_pin_in,
  input wire logic [17:0] b_pin_out,
  input wire logic b_pin_oe_out,
  input wire logic a_to_b_capture_ready_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_ab_drive_on: assert property (a_to_b_output_enable_in |=> b_pin_oe_out)
    else $error("B drive late");
  a_ab_drive_off: assert property (!a_to_b_output_enable_in |=> !b_pin_oe_out)
    else $error("B not released");
  a_ba_drive_on: assert property (!b_to_a_output_enable_n_in |=> a_pin_oe_out)
    else $error("A drive late");
  a_ba_drive_off: assert property (b_to_a_output_enable_n_in |=> !a_pin_oe_out)
    else $error("A not released");
  a_ab_flow_thru: assert property ((a_to_b_latch_enable_in && a_to_b_output_enable_in &&
    !a_pin_oe_out)[*3] |-> b_pin_out == $past(a_pin_in, 2))
    else $error("B not following A");
  a_ba_flow_thru: assert property ((b_to_a_latch_enable_in && !b_to_a_output_enable_n_in &&
    !b_pin_oe_out)[*3] |-> a_pin_out == $past(b_pin_in, 2))
    else $error("A not following B");
  a_ab_hold_out: assert property ((!a_to_b_latch_enable_in && !a_to_b_output_enable_in)[*2]
    |=> $stable(b_pin_out))
    else $error("B changed while held");
  a_ba_hold_out: assert property ((!b_to_a_latch_enable_in && b_to_a_output_enable_n_in)[*2]
    |=> $stable(a_pin_out))
    else $error("A changed while held");
  c_ab_full: cover property ($fell(a_to_b_capture_ready_out));
  c_ab_thru: cover property (a_to_b_latch_enable_in && b_pin_oe_out);
  c_ba_thru: cover property (b_to_a_latch_enable_in && a_pin_oe_out);
endmodule // bxcvr_props

// ===== bxcvr_far_bus.sv
// Purpose: Far-side bus driver sharing one wire with the device.
// Assumes: The far side yields whenever the device drives.
// Notes: Yielding avoids contention, so the wire never resolves to X.
`timescale 1ns/1ps
module bxcvr_far_bus (
  // Device side
  input wire logic [17:0] dev_data_in,
  input wire logic dev_oe_in,
  // Far side
  input wire logic [17:0] ext_data_in,
  output logic [17:0] wire_out
);
  assign wire_out = dev_oe_in ? dev_data_in : ext_data_in;
endmodule // bxcvr_far_bus

// ===== bxcvr_top_bench.sv
// Purpose: Scenario bench for the transceiver.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: One direction drives at a time to keep the wires free of loops.
`timescale 1ns/1ps
module bxcvr_top_bench;
  logic clk_in, rst_in, ab_oe, ab_le, ab_ck, ba_oen, ba_le, ba_ck, a_oe, b_oe, ab_rdy, ba_rdy;
  logic [17:0] a_ext, b_ext, a_w, b_w, a_o, b_o;
  int fails, total_checks;
  bxcvr_top u_bxcvr_top (.clk_in, .rst_in, .a_to_b_output_enable_in(ab_oe),
    .a_to_b_latch_enable_in(ab_le), .a_to_b_clock_n_in(ab_ck),
    .b_to_a_output_enable_n_in(ba_oen), .b_to_a_latch_enable_in(ba_le),
    .b_to_a_clock_n_in(ba_ck), .a_pin_in(a_w), .a_pin_out(a_o), .a_pin_oe_out(a_oe),
    .b_pin_in(b_w), .b_pin_out(b_o), .b_pin_oe_out(b_oe),
    .a_to_b_capture_ready_out(ab_rdy), .b_to_a_capture_ready_out(ba_rdy));
  bxcvr_far_bus u_bxcvr_far_bus_a (.dev_data_in(a_o), .dev_oe_in(a_oe), .ext_data_in(a_ext),
    .wire_out(a_w));
  bxcvr_far_bus u_bxcvr_far_bus_b (.dev_data_in(b_o), .dev_oe_in(b_oe), .ext_data_in(b_ext),
    .wire_out(b_w));
  task step(input int n); repeat (n) @(posedge clk_in); #1; endtask
  task chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task t_ab;
    ab_le = 1; ab_oe = 1; a_ext = 18'h2A5A5; step(3);
    chk("b_out", b_o, 18'h2A5A5);
    chk("b_oe", 18'(b_oe), 18'h00001);
    ab_le = 0; step(1); a_ext = 18'h01234; step(3);
    chk("b_held", b_o, 18'h2A5A5);
    ab_ck = 1; step(1); ab_ck = 0; step(4);
    chk("b_capt", b_o, 18'h01234);
    a_ext = 18'h3FFFF; step(3);
    chk("b_low", b_o, 18'h01234);
    ab_oe = 0; step(2);
    chk("b_oe", 18'(b_oe), 18'h00000);
  endtask
  task t_ba;
    ba_oen = 0; ba_le = 1; b_ext = 18'h15A5A; step(3);
    chk("a_out", a_o, 18'h15A5A);
    chk("a_oe", 18'(a_oe), 18'h00001);
    chk("ba_rdy", 18'(ba_rdy), 18'h00001);
    ba_le = 0; ba_ck = 1; b_ext = 18'h00F0F; step(2); ba_ck = 0; step(4);
    chk("a_capt", a_o, 18'h00F0F);
    ba_oen = 1; step(2);
    chk("a_oe", 18'(a_oe), 18'h00000);
  endtask
  // Seventeen words fit: sixteen in memory and one in the output stage.
  task t_fifo;
    for (int i = 1; i <= 20; i++) begin
      a_ext = 18'(i); ab_ck = 1; step(1); ab_ck = 0; step(1);
    end
    step(2);
    chk("rdy_full", 18'(ab_rdy), 18'h00000);
    ab_oe = 1; step(25);
    chk("rdy_free", 18'(ab_rdy), 18'h00001);
    chk("b_last", b_o, 18'h00011);
  endtask
  initial begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    #5000; fails++; give_verdict;
  end
  initial begin
    {ab_oe, ab_le, ab_ck, ba_le, ba_ck} = 5'h00; ba_oen = 1; a_ext = 0; b_ext = 0;
    fails = 0; total_checks = 0; rst_in = 1; step(20); rst_in = 0; step(1);
    t_ab; t_ba; t_fifo; give_verdict;
  end
endmodule // bxcvr_top_bench
bind bxcvr_top bxcvr_props u_bxcvr_props (.clk_in, .rst_in, .a_to_b_output_enable_in,
  .a_to_b_latch_enable_in, .b_to_a_output_enable_n_in, .b_to_a_latch_enable_in, .a_pin_in,
  .a_pin_out, .a_pin_oe_out, .b_pin_in, .b_pin_out, .b_pin_oe_out, .a_to_b_capture_ready_out);
